// file: rtl/charge_sweep.sv
// automatic charging mode sequencer for one downstream port
`timescale 1ns/1ps
`include "hub_cfg_reg_cfg.svh"
module charge_sweep
  import hub_cfg_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // control
  input wire logic auto_enable,
  input wire logic port_charge_enable,
  input wire logic sweep_enable,
  input wire logic vendor_disable,
  input wire logic device_attached,
  // current mode
  output charge_mode_t charge_mode
);
  charge_mode_t mode_reg;
  charge_mode_t mode_next;
  logic [15:0] step_reg;
  logic [15:0] step_next;
  logic step_done;

  always_comb
  begin
    mode_next = mode_reg;
    step_next = step_reg + 16'h0001;
    step_done = (step_reg == `CHARGE_STEP_CYCLES);
    if (!auto_enable || !port_charge_enable)
    begin
      mode_next = CHG_IDLE;
      step_next = 16'h0000;
    end
    else if (device_attached)
    begin
      step_next = 16'h0000;
    end
    else
    begin
      case (mode_reg)
        // sweep from highest current down
        CHG_IDLE: mode_next = sweep_enable ? CHG_DIV_HIGH : CHG_DIV_LOW;
        CHG_DIV_HIGH: if (step_done) mode_next = CHG_DIV_MID;
        CHG_DIV_MID: if (step_done) mode_next = CHG_DIV_LOW;
        CHG_DIV_LOW: if (step_done) mode_next = vendor_disable ? CHG_DEDICATED : CHG_VENDOR;
        CHG_VENDOR: if (step_done) mode_next = CHG_DEDICATED;
        CHG_DEDICATED: mode_next = CHG_DEDICATED;
        default: mode_next = CHG_IDLE;
      endcase
      if (mode_next != mode_reg)
      begin
        step_next = 16'h0000;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_reg <= CHG_IDLE;
      step_reg <= 16'h0000;
    end
    else
    begin
      mode_reg <= mode_next;
      step_reg <= step_next;
    end
  end

  assign charge_mode = mode_reg;
endmodule

// file: rtl/hub_cfg_pkg.sv
// types shared by the hub configuration slice
package hub_cfg_pkg;
  typedef enum logic [2:0] {
    CHG_IDLE = 3'b000,
    CHG_DIV_HIGH = 3'b001,
    CHG_DIV_MID = 3'b011,
    CHG_DIV_LOW = 3'b010,
    CHG_VENDOR = 3'b110,
    CHG_DEDICATED = 3'b111
  } charge_mode_t;
endpackage

// file: rtl/hub_cfg_reg_cfg.svh
// offsets, field positions, reset values and timing counts of the hub config slice
// Notes on behaviour
// - Reserved bit 7 of the product length register and bits 7:5 of the third config register read zero and ignore writes.
// - The product length field resets to zero, and zero means no product string is offered.
// - The product length field takes writes from the EEPROM or SMBus only while custom strings are enabled.
// - A nonzero product length makes a string request for index three return that many bytes of product string storage.
// - The slow-rate bit runs the serial master at 100 kHz for USB-originated serial bus requests.
// - EEPROM reads run at 400 kHz unless a fuse selects the slow rate.
// - A fuse bit alone can select the 100 kHz serial master rate.
// - The slow-rate and vendor charge disable bits read as register OR fuse, and act when either is one, except that EEPROM reads follow the slow-rate fuse alone.
// - With vendor charge disable high the vendor compatible mode is skipped in the automatic charging sequence.
// - With automatic charging and the sweep bit set, each charging port tries all divider modes before the dedicated mode.
// - The divider sweep goes in order of decreasing current, highest first.
// - The sweep bit is writable, reads as register OR fuse, and enables the sweep when either is set.
`ifndef HUB_CFG_REG_CFG_SVH
`define HUB_CFG_REG_CFG_SVH
`define PROD_LEN_OFFSET 8'h24
`define FEAT_CFG3_OFFSET 8'h25
`define PROD_LEN_RESET 7'h00
`define FEAT_CFG3_RESET 5'h00
`define PROD_LEN_MSB 6
`define CFG3_LEGACY_BIT 4
`define CFG3_RSVD3_BIT 3
`define CFG3_SLOW_BIT 2
`define CFG3_VENDOR_BIT 1
`define CFG3_SWEEP_BIT 0
`define STRING_INDEX_PRODUCT 8'h03
`define PROD_LEN_MAX 7'h40
`define CORE_CLK_HZ 100000000
`define SLOW_RATE_HZ 100000
`define FAST_RATE_HZ 400000
`define SLOW_HALF_CYCLES (`CORE_CLK_HZ / (2 * `SLOW_RATE_HZ))
`define FAST_HALF_CYCLES (`CORE_CLK_HZ / (2 * `FAST_RATE_HZ))
`define CHARGE_STEP_CYCLES 16'h0400
`endif

// file: rtl/hub_string_and_feature_config.sv
// product string length and third feature configuration registers with consumers
`timescale 1ns/1ps
`include "hub_cfg_reg_cfg.svh"
module hub_string_and_feature_config
  import hub_cfg_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // configuration write port (eeprom loader or smbus slave)
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic custom_strings_enable,
  // configuration read port
  input wire logic [7:0] cfg_rd_addr,
  output logic [7:0] cfg_rdata,
  // fuse bits
  input wire logic fuse_legacy_speed_only,
  input wire logic fuse_serial_master_slow_rate,
  input wire logic fuse_vendor_charge_disable,
  input wire logic fuse_divider_charge_sweep_enable,
  // string descriptor request
  input wire logic str_req,
  input wire logic [7:0] str_index,
  output logic str_offered,
  output logic [6:0] str_len,
  // product string storage fetch
  output logic [5:0] prod_mem_addr,
  output logic prod_mem_rd,
  input wire logic [7:0] prod_mem_data,
  output logic [7:0] str_byte,
  output logic str_byte_valid,
  output logic str_done,
  // serial master
  input wire logic serial_from_usb,
  output logic serial_tick,
  // speed control
  output logic superspeed_advertise,
  output logic superspeed_hub_enable,
  // charging
  input wire logic auto_charge_enable,
  input wire logic [3:0] port_charge_enable,
  input wire logic [3:0] port_attached,
  output charge_mode_t port_charge_mode [4]
);
  // ****************************************
  // registers
  // ****************************************
  logic [6:0] prod_len_reg;
  logic [6:0] prod_len_next;
  logic [4:0] cfg3_reg;
  logic [4:0] cfg3_next;
  logic slow_eff;
  logic vendor_eff;
  logic sweep_eff;
  logic legacy_eff;

  always_comb
  begin
    prod_len_next = prod_len_reg;
    cfg3_next = cfg3_reg;
    if (cfg_wr && cfg_addr == `PROD_LEN_OFFSET && custom_strings_enable)
    begin
      prod_len_next = cfg_wdata[`PROD_LEN_MSB:0];
    end
    if (cfg_wr && cfg_addr == `FEAT_CFG3_OFFSET)
    begin
      cfg3_next = cfg_wdata[4:0];
      cfg3_next[`CFG3_RSVD3_BIT] = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prod_len_reg <= `PROD_LEN_RESET;
      cfg3_reg <= `FEAT_CFG3_RESET;
    end
    else
    begin
      prod_len_reg <= prod_len_next;
      cfg3_reg <= cfg3_next;
    end
  end

  // fuse merges: feature active if either source set
  assign legacy_eff = cfg3_reg[`CFG3_LEGACY_BIT] | fuse_legacy_speed_only;
  assign slow_eff = cfg3_reg[`CFG3_SLOW_BIT] | fuse_serial_master_slow_rate;
  assign vendor_eff = cfg3_reg[`CFG3_VENDOR_BIT] | fuse_vendor_charge_disable;
  assign sweep_eff = cfg3_reg[`CFG3_SWEEP_BIT] | fuse_divider_charge_sweep_enable;

  // ****************************************
  // read mux
  // ****************************************
  logic [7:0] rdata_next;
  logic [7:0] rdata_reg;

  always_comb
  begin
    case (cfg_rd_addr)
      `PROD_LEN_OFFSET: rdata_next = {1'b0, prod_len_reg};
      `FEAT_CFG3_OFFSET: rdata_next = {3'b000, legacy_eff, 1'b0, slow_eff, vendor_eff,
                                       sweep_eff};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign cfg_rdata = rdata_reg;

  // ****************************************
  // product string streaming
  // ****************************************
  logic busy_reg;
  logic busy_next;
  logic [6:0] idx_reg;
  logic [6:0] idx_next;
  logic fetch_reg;
  logic fetch_next;
  logic last_reg;
  logic last_next;
  logic [7:0] byte_reg;
  logic [7:0] byte_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic done_reg;
  logic done_next;
  logic offered_reg;
  logic offered_next;

  always_comb
  begin
    busy_next = busy_reg;
    idx_next = idx_reg;
    fetch_next = 1'b0;
    last_next = last_reg;
    byte_next = byte_reg;
    bvalid_next = fetch_reg;
    done_next = 1'b0;
    offered_next = offered_reg;
    if (fetch_reg)
    begin
      byte_next = prod_mem_data;
      done_next = last_reg;
    end
    if (!busy_reg && str_req && str_index == `STRING_INDEX_PRODUCT)
    begin
      offered_next = (prod_len_reg != 7'h00);
      if (prod_len_reg != 7'h00)
      begin
        busy_next = 1'b1;
        idx_next = 7'h00;
      end
    end
    else if (busy_reg)
    begin
      fetch_next = 1'b1;
      last_next = (idx_reg == prod_len_reg - 7'h01);
      idx_next = idx_reg + 7'h01;
      if (idx_reg == prod_len_reg - 7'h01)
      begin
        busy_next = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy_reg <= 1'b0;
      idx_reg <= 7'h00;
      fetch_reg <= 1'b0;
      last_reg <= 1'b0;
      byte_reg <= 8'h00;
      bvalid_reg <= 1'b0;
      done_reg <= 1'b0;
      offered_reg <= 1'b0;
    end
    else
    begin
      busy_reg <= busy_next;
      idx_reg <= idx_next;
      fetch_reg <= fetch_next;
      last_reg <= last_next;
      byte_reg <= byte_next;
      bvalid_reg <= bvalid_next;
      done_reg <= done_next;
      offered_reg <= offered_next;
    end
  end

  // storage is 64 bytes deep; lengths above that wrap, the configurer must not do it
  assign prod_mem_addr = idx_reg[5:0];
  assign prod_mem_rd = busy_reg;
  assign str_byte = byte_reg;
  assign str_byte_valid = bvalid_reg;
  assign str_done = done_reg;
  assign str_offered = offered_reg;
  assign str_len = prod_len_reg;

  // ****************************************
  // serial master rate
  // ****************************************
  // eeprom reads stay fast unless the fuse asks for slow
  logic rate_slow;
  assign rate_slow = serial_from_usb ? slow_eff : fuse_serial_master_slow_rate;

  serial_rate_gen u_rate (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .slow_sel(rate_slow),
    .scl_toggle(serial_tick)
  );

  // ****************************************
  // speed control
  // ****************************************
  logic ss_reg;
  logic ss_next;

  always_comb
  begin
    ss_next = ~legacy_eff;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ss_reg <= 1'b0;
    end
    else
    begin
      ss_reg <= ss_next;
    end
  end
  assign superspeed_advertise = ss_reg;
  assign superspeed_hub_enable = ss_reg;

  // ****************************************
  // attach detect synchroniser
  // ****************************************
  // attach status comes from the port pins, so it is resampled before use
  logic [3:0] att_s1_reg;
  logic [3:0] att_s1_next;
  logic [3:0] att_s2_reg;
  logic [3:0] att_s2_next;
  logic [3:0] att_s3_reg;
  logic [3:0] att_s3_next;
  logic [3:0] att_reg;
  logic [3:0] att_next;

  always_comb
  begin
    att_s1_next = port_attached;
    att_s2_next = att_s1_reg;
    att_s3_next = att_s2_reg;
    // a change counts only once the last two stages agree
    att_next = (att_s2_reg & att_s3_reg) | (att_reg & (att_s2_reg ^ att_s3_reg));
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      att_s1_reg <= 4'h0;
      att_s2_reg <= 4'h0;
      att_s3_reg <= 4'h0;
      att_reg <= 4'h0;
    end
    else
    begin
      att_s1_reg <= att_s1_next;
      att_s2_reg <= att_s2_next;
      att_s3_reg <= att_s3_next;
      att_reg <= att_next;
    end
  end

  // ****************************************
  // charging sequencers
  // ****************************************
  genvar p;
  generate
    for (p = 0; p < 4; p++)
    begin : g_port
      charge_sweep u_sweep (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .auto_enable(auto_charge_enable),
        .port_charge_enable(port_charge_enable[p]),
        .sweep_enable(sweep_eff),
        .vendor_disable(vendor_eff),
        .device_attached(att_reg[p]),
        .charge_mode(port_charge_mode[p])
      );
    end
  endgenerate
endmodule

// file: rtl/serial_rate_gen.sv
// serial master clock tick generator, 100 kHz or 400 kHz
`timescale 1ns/1ps
`include "hub_cfg_reg_cfg.svh"
module serial_rate_gen (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // rate choice
  input wire logic slow_sel,
  // tick at twice the bit rate
  output logic scl_toggle
);
  logic [8:0] cnt_reg;
  logic [8:0] cnt_next;
  logic tick_next;
  logic tick_reg;
  logic [8:0] limit;

  always_comb
  begin
    limit = slow_sel ? 9'(`SLOW_HALF_CYCLES - 1) : 9'(`FAST_HALF_CYCLES - 1);
    tick_next = 1'b0;
    cnt_next = cnt_reg + 9'h001;
    if (cnt_reg >= limit)
    begin
      cnt_next = 9'h000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_reg <= 9'h000;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign scl_toggle = tick_reg;
endmodule

// file: test/hub_cfg_sva.sv
// port assertions for the hub config slice
`timescale 1ns/1ps
module hub_cfg_sva
  import hub_cfg_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // watched ports
  input wire logic [7:0] cfg_rd_addr,
  input wire logic [7:0] cfg_rdata,
  input wire logic fuse_legacy_speed_only,
  input wire logic fuse_serial_master_slow_rate,
  input wire logic fuse_vendor_charge_disable,
  input wire logic [6:0] str_len,
  input wire logic prod_mem_rd,
  input wire logic serial_tick,
  input wire logic superspeed_advertise,
  input wire logic superspeed_hub_enable,
  input wire charge_mode_t port_charge_mode [4]
);
  logic [15:0] gap_reg, gap_next;
  logic armed_reg, armed_next;
  // armed only while the slow fuse held since the last tick
  always_comb
  begin
    gap_next = serial_tick ? 16'h0000 : gap_reg + 16'h0001;
    armed_next = serial_tick ? fuse_serial_master_slow_rate
                             : armed_reg & fuse_serial_master_slow_rate;
  end
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gap_reg <= 16'h0000;
      armed_reg <= 1'b0;
    end
    else
    begin
      gap_reg <= gap_next;
      armed_reg <= armed_next;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_PLEN_RSVD: assert property ($past(cfg_rd_addr) == 8'h24 |-> !cfg_rdata[7])
    else $error("product length bit 7 not zero");
  AST_CFG3_RSVD: assert property ($past(cfg_rd_addr) == 8'h25 |-> cfg_rdata[7:5] == 3'h0)
    else $error("cfg3 bits 7:5 not zero");
  AST_LEGACY: assert property (
    fuse_legacy_speed_only |=> !superspeed_advertise && !superspeed_hub_enable)
    else $error("superspeed still on with legacy fuse");
  AST_VENDOR_RD: assert property (
    $past(cfg_rd_addr) == 8'h25 && $past(fuse_vendor_charge_disable) |-> cfg_rdata[1])
    else $error("vendor fuse not ored into read");
  AST_NO_STRING: assert property (str_len == 7'h00 |-> !prod_mem_rd)
    else $error("string fetch with zero length");
  AST_NO_VENDOR: assert property (
    port_charge_mode[0] == CHG_VENDOR && $past(port_charge_mode[0]) != CHG_VENDOR
    |-> !$past(fuse_vendor_charge_disable))
    else $error("vendor mode entered while disabled");
  AST_DIV_ORDER: assert property (
    port_charge_mode[0] == CHG_DIV_MID && $past(port_charge_mode[0]) != CHG_DIV_MID
    |-> $past(port_charge_mode[0]) == CHG_DIV_HIGH)
    else $error("mid divider not after high");
  AST_FUSE_SLOW: assert property (serial_tick && armed_reg |-> gap_reg == 16'h01f3)
    else $error("slow fuse tick period wrong");
endmodule
bind hub_string_and_feature_config hub_cfg_sva i_sva (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .cfg_rd_addr(cfg_rd_addr),
  .cfg_rdata(cfg_rdata),
  .fuse_legacy_speed_only(fuse_legacy_speed_only),
  .fuse_serial_master_slow_rate(fuse_serial_master_slow_rate),
  .fuse_vendor_charge_disable(fuse_vendor_charge_disable),
  .str_len(str_len),
  .prod_mem_rd(prod_mem_rd),
  .serial_tick(serial_tick),
  .superspeed_advertise(superspeed_advertise),
  .superspeed_hub_enable(superspeed_hub_enable),
  .port_charge_mode(port_charge_mode)
);

// file: test/hub_string_and_feature_config_tb_top.sv
// self-checking bench for the hub config slice
`timescale 1ns/1ps
module hub_string_and_feature_config_tb_top;
  import hub_cfg_pkg::*;
  logic core_clk, sys_rst, cfg_wr, cse, str_req, from_usb, auto_en, f_leg, f_slow, f_ven, f_swp;
  logic [7:0] cfg_addr, cfg_wdata, rd_addr, rdata, str_index, mdata, str_byte;
  logic [6:0] str_len;
  logic [5:0] maddr;
  logic [3:0] pce;
  logic mrd, offered, bvalid, done, tick, ss_adv, ss_en;
  charge_mode_t modes [4];
  charge_mode_t seq [4];
  int n_fail, check_count, cyc, i;
  hub_string_and_feature_config i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .custom_strings_enable(cse),
    .cfg_rd_addr(rd_addr), .cfg_rdata(rdata), .fuse_legacy_speed_only(f_leg),
    .fuse_serial_master_slow_rate(f_slow), .fuse_vendor_charge_disable(f_ven),
    .fuse_divider_charge_sweep_enable(f_swp), .str_req(str_req), .str_index(str_index),
    .str_offered(offered), .str_len(str_len), .prod_mem_addr(maddr), .prod_mem_rd(mrd),
    .prod_mem_data(mdata), .str_byte(str_byte), .str_byte_valid(bvalid), .str_done(done),
    .serial_from_usb(from_usb), .serial_tick(tick), .superspeed_advertise(ss_adv),
    .superspeed_hub_enable(ss_en), .auto_charge_enable(auto_en), .port_charge_enable(pce),
    .port_attached(4'h0), .port_charge_mode(modes));
  prod_string_mem_model i_mem (.core_clk(core_clk), .prod_mem_addr(maddr),
    .prod_mem_rd(mrd), .prod_mem_data(mdata));
  initial
  begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  // ****************
  // tasks
  // ****************
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cfg_wr <= 1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge core_clk);
    cfg_wr <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    rd_addr <= a;
    repeat (2) @(posedge core_clk);
    #1 chk(rdata, e);
  endtask
  task wt;
    do @(posedge core_clk); while (tick !== 1'b1);
  endtask
  task per(input int e);
    int n;
    wt();
    wt();
    n = 0;
    do begin @(posedge core_clk); n++; end while (tick !== 1'b1);
    chk(16'(n), 16'(e));
  endtask
  task strq;
    @(posedge core_clk);
    str_req <= 1;
    @(posedge core_clk);
    str_req <= 0;
  endtask
  task grab(input int n);
    for (int k = 0; k < n; k++)
    begin
      do @(posedge core_clk); while (modes[0] === CHG_IDLE || (k > 0 && modes[0] === seq[k-1]));
      seq[k] = modes[0];
    end
  endtask
  // ****************
  // cycle ceiling, then main sequence
  // ****************
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      end_sim();
    end
  end
  initial
  begin
    {sys_rst, cfg_wr, cse, str_req, from_usb, auto_en, f_leg, f_slow, f_ven, f_swp} = 10'h200;
    {cfg_addr, cfg_wdata, rd_addr, pce} = 28'h0;
    str_index = 8'h03;
    n_fail = 0;
    check_count = 0;
    cyc = 0;
    repeat (4) @(posedge core_clk);
    sys_rst <= 0;
    rd(8'h24, 8'h00);
    rd(8'h25, 8'h00);
    wr(8'h24, 8'h05);
    rd(8'h24, 8'h00);
    cse <= 1;
    wr(8'h24, 8'hc0);
    rd(8'h24, 8'h40);
    wr(8'h25, 8'hff);
    rd(8'h25, 8'h17);
    chk({ss_adv, ss_en}, 2'b00);
    wr(8'h25, 8'h00);
    {f_leg, f_slow, f_ven, f_swp} <= 4'hf;
    rd(8'h25, 8'h17);
    {f_leg, f_slow, f_ven, f_swp} <= 4'h0;
    rd(8'h25, 8'h00);
    chk({ss_adv, ss_en}, 2'b11);
    // length kept at or below 64 bytes
    wr(8'h24, 8'h03);
    strq();
    chk(str_len, 7'h03);
    for (i = 0; i < 3; i++)
    begin
      do @(posedge core_clk); while (bvalid !== 1'b1);
      chk(str_byte, 16'(8'h80 + i));
    end
    chk(done, 1'b1);
    #1 chk(offered, 1'b1);
    wr(8'h24, 8'h00);
    strq();
    repeat (6) @(posedge core_clk);
    chk({offered, bvalid}, 2'b00);
    wr(8'h25, 8'h04);
    from_usb <= 1;
    per(500);
    from_usb <= 0;
    per(125);
    wr(8'h25, 8'h00);
    f_slow <= 1;
    per(500);
    f_slow <= 0;
    wr(8'h25, 8'h03);
    auto_en <= 1;
    pce <= 4'hf;
    grab(4);
    chk(seq[0], CHG_DIV_HIGH);
    chk(seq[1], CHG_DIV_MID);
    chk(seq[2], CHG_DIV_LOW);
    chk(seq[3], CHG_DEDICATED);
    chk(modes[3], CHG_DEDICATED);
    // sweep off and vendor mode allowed, only port 0 charging
    auto_en <= 0;
    wr(8'h25, 8'h00);
    pce <= 4'h1;
    auto_en <= 1;
    grab(3);
    chk(seq[0], CHG_DIV_LOW);
    chk(seq[1], CHG_VENDOR);
    chk(seq[2], CHG_DEDICATED);
    chk(modes[1], CHG_IDLE);
    end_sim();
  end
endmodule

// file: test/prod_string_mem_model.sv
// product string storage model, synchronous read
`timescale 1ns/1ps
module prod_string_mem_model (
  // clock
  input wire logic core_clk,
  // fetch
  input wire logic [5:0] prod_mem_addr,
  input wire logic prod_mem_rd,
  output logic [7:0] prod_mem_data
);
  // idle cycles invert the last output, so stale data looks valid again on every second idle cycle
  always_ff @(posedge core_clk)
  begin
    prod_mem_data <= prod_mem_rd ? {2'b10, prod_mem_addr} : ~prod_mem_data;
  end
endmodule
